// ---- design/gpio_ports.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_ports (
	input  wire logic                       i_clk,
	input  wire logic                       i_srst,
	// software access, one shared write data word
	input  wire logic [gpio_pkg::WDATA_W-1:0] i_wdata,
	input  wire logic                       i_port_a_cfg_wr,
	input  wire logic                       i_port_a_dir_wr,
	input  wire logic                       i_port_a_data_wr,
	input  wire logic                       i_port_a_od_wr,
	input  wire logic                       i_port_b_cfg_wr,
	input  wire logic                       i_port_b_dir_wr,
	input  wire logic                       i_port_b_data_wr,
	input  wire logic                       i_port_b_od_wr,
	input  wire logic                       i_port_c_cfg_wr,
	input  wire logic                       i_port_c_dir_wr,
	input  wire logic                       i_port_c_data_wr,
	input  wire logic                       i_port_c_od_wr,
	output logic      [gpio_pkg::A_W-1:0]   o_port_a_cfg,
	output logic      [gpio_pkg::A_W-1:0]   o_port_a_dir,
	output logic                            o_port_a_od,
	output logic      [gpio_pkg::A_W-1:0]   o_port_a_rd_data,
	output logic      [gpio_pkg::B_W-1:0]   o_port_b_cfg,
	output logic      [gpio_pkg::B_W-1:0]   o_port_b_dir,
	output logic                            o_port_b_od,
	output logic      [gpio_pkg::B_W-1:0]   o_port_b_rd_data,
	output logic      [gpio_pkg::C_W-1:0]   o_port_c_cfg,
	output logic      [gpio_pkg::C_W-1:0]   o_port_c_dir,
	output logic                            o_port_c_od,
	output logic      [gpio_pkg::C_W-1:0]   o_port_c_rd_data,
	// pads: input, output and active-low output enable
	input  wire logic [gpio_pkg::A_W-1:0]   i_port_a_pin,
	output logic      [gpio_pkg::A_W-1:0]   o_port_a_pin,
	output logic      [gpio_pkg::A_W-1:0]   o_port_a_pin_oe_n,
	input  wire logic [gpio_pkg::B_W-1:0]   i_port_b_pin,
	output logic      [gpio_pkg::B_W-1:0]   o_port_b_pin,
	output logic      [gpio_pkg::B_W-1:0]   o_port_b_pin_oe_n,
	input  wire logic [gpio_pkg::C_W-1:0]   i_port_c_pin,
	output logic      [gpio_pkg::C_W-1:0]   o_port_c_pin,
	output logic      [gpio_pkg::C_W-1:0]   o_port_c_pin_oe_n,
	// peripheral side, same clock domain
	input  wire logic                       i_serial_one_transmit,
	input  wire logic                       i_serial_two_transmit,
	input  wire logic                       i_spi_one_is_master,
	input  wire logic                       i_spi_one_master_in,
	input  wire logic                       i_spi_one_master_out,
	input  wire logic                       i_spi_one_clock,
	input  wire logic                       i_spi_two_is_master,
	input  wire logic                       i_spi_two_master_in,
	input  wire logic                       i_spi_two_master_out,
	input  wire logic                       i_spi_two_clock,
	input  wire logic                       i_can_transmit_out,
	input  wire logic                       i_usb_drive,
	input  wire logic                       i_usb_minus_line,
	input  wire logic                       i_usb_plus_line,
	input  wire logic                       i_stop_request_n,
	input  wire logic                       i_synth_lock,
	input  wire logic                       i_ext_memory_bank1_select_n,
	output logic                            o_serial_one_receive,
	output logic                            o_serial_two_receive,
	output logic                            o_spi_one_master_in,
	output logic                            o_spi_one_master_out,
	output logic                            o_spi_one_clock,
	output logic                            o_spi_two_master_in,
	output logic                            o_spi_two_master_out,
	output logic                            o_spi_two_clock,
	output logic                            o_usb_ref_clock_in,
	output logic                            o_can_receive_in,
	output logic                            o_timer_one_external_clock,
	output logic                            o_usb_minus_line,
	output logic                            o_usb_plus_line,
	output logic      [gpio_pkg::IRQ_N-1:0] o_external_irq,
	output logic                            o_spi_one_slave_select,
	output logic                            o_spi_two_slave_select,
	output logic                            o_timer_two_capture_b,
	output logic                            o_ext_memory_ready,
	output logic                            o_boot_source_strap
);
	logic [gpio_pkg::A_W-1:0] a_alt_out, a_alt_oe, a_level;
	logic [gpio_pkg::B_W-1:0] b_alt_out, b_alt_oe, b_level;
	logic [gpio_pkg::C_W-1:0] c_alt_out, c_alt_oe, c_level;
	logic                     strap_reg, strap_next;

	// port a peripheral drivers; input-only functions leave oe low
	always_comb
	begin
		a_alt_out = '0;
		a_alt_oe = '0;
		a_alt_out[gpio_pkg::A_TX1] = i_serial_one_transmit;
		a_alt_oe[gpio_pkg::A_TX1] = 1'b1;
		a_alt_out[gpio_pkg::A_TX2] = i_serial_two_transmit;
		a_alt_oe[gpio_pkg::A_TX2] = 1'b1;
		// master drives data-out and clock, slave drives data-in
		a_alt_out[gpio_pkg::A_SPI1_MI] = i_spi_one_master_in;
		a_alt_oe[gpio_pkg::A_SPI1_MI] = ~i_spi_one_is_master;
		a_alt_out[gpio_pkg::A_SPI1_MO] = i_spi_one_master_out;
		a_alt_oe[gpio_pkg::A_SPI1_MO] = i_spi_one_is_master;
		a_alt_out[gpio_pkg::A_SPI1_CK] = i_spi_one_clock;
		a_alt_oe[gpio_pkg::A_SPI1_CK] = i_spi_one_is_master;
		a_alt_out[gpio_pkg::A_SPI2_MI] = i_spi_two_master_in;
		a_alt_oe[gpio_pkg::A_SPI2_MI] = ~i_spi_two_is_master;
		a_alt_out[gpio_pkg::A_SPI2_MO] = i_spi_two_master_out;
		a_alt_oe[gpio_pkg::A_SPI2_MO] = i_spi_two_is_master;
		a_alt_out[gpio_pkg::A_SPI2_CK] = i_spi_two_clock;
		a_alt_oe[gpio_pkg::A_SPI2_CK] = i_spi_two_is_master;
		a_alt_out[gpio_pkg::A_CAN_TX] = i_can_transmit_out;
		a_alt_oe[gpio_pkg::A_CAN_TX] = 1'b1;
		// usb lines reach the pads only while i_usb_drive is high, each line on its own cfg bit
		a_alt_out[gpio_pkg::A_USB_MINUS] = i_usb_minus_line;
		a_alt_oe[gpio_pkg::A_USB_MINUS] = i_usb_drive;
		a_alt_out[gpio_pkg::A_USB_PLUS] = i_usb_plus_line;
		a_alt_oe[gpio_pkg::A_USB_PLUS] = i_usb_drive;
	end

	// port b and c peripheral drivers
	always_comb
	begin
		b_alt_out = '0;
		b_alt_oe = '0;
		c_alt_out = '0;
		c_alt_oe = '0;
		b_alt_out[gpio_pkg::B_STOP] = i_stop_request_n;
		b_alt_oe[gpio_pkg::B_STOP] = 1'b1;
		// lock output wins over the irq 3 input when the line is peripheral
		b_alt_out[gpio_pkg::B_LOCK] = i_synth_lock;
		b_alt_oe[gpio_pkg::B_LOCK] = 1'b1;
		c_alt_out[gpio_pkg::C_BANK1] = i_ext_memory_bank1_select_n;
		c_alt_oe[gpio_pkg::C_BANK1] = 1'b1;
	end

	// one instance per port
	gpio_port_lines #(
		.W(gpio_pkg::A_W)
	) u_port_a (
		.i_clk      (i_clk),
		.i_srst     (i_srst),
		.i_cfg_wr   (i_port_a_cfg_wr),
		.i_dir_wr   (i_port_a_dir_wr),
		.i_data_wr  (i_port_a_data_wr),
		.i_od_wr    (i_port_a_od_wr),
		.i_wdata    (i_wdata[gpio_pkg::A_W-1:0]),
		.i_alt_out  (a_alt_out),
		.i_alt_oe   (a_alt_oe),
		.i_pin_in   (i_port_a_pin),
		.o_pin_out  (o_port_a_pin),
		.o_pin_oe_n (o_port_a_pin_oe_n),
		.o_pin_level(a_level),
		.o_cfg      (o_port_a_cfg),
		.o_dir      (o_port_a_dir),
		.o_od       (o_port_a_od),
		.o_rd_data  (o_port_a_rd_data)
	);

	gpio_port_lines #(
		.W(gpio_pkg::B_W)
	) u_port_b (
		.i_clk      (i_clk),
		.i_srst     (i_srst),
		.i_cfg_wr   (i_port_b_cfg_wr),
		.i_dir_wr   (i_port_b_dir_wr),
		.i_data_wr  (i_port_b_data_wr),
		.i_od_wr    (i_port_b_od_wr),
		.i_wdata    (i_wdata[gpio_pkg::B_W-1:0]),
		.i_alt_out  (b_alt_out),
		.i_alt_oe   (b_alt_oe),
		.i_pin_in   (i_port_b_pin),
		.o_pin_out  (o_port_b_pin),
		.o_pin_oe_n (o_port_b_pin_oe_n),
		.o_pin_level(b_level),
		.o_cfg      (o_port_b_cfg),
		.o_dir      (o_port_b_dir),
		.o_od       (o_port_b_od),
		.o_rd_data  (o_port_b_rd_data)
	);

	gpio_port_lines #(
		.W(gpio_pkg::C_W)
	) u_port_c (
		.i_clk      (i_clk),
		.i_srst     (i_srst),
		.i_cfg_wr   (i_port_c_cfg_wr),
		.i_dir_wr   (i_port_c_dir_wr),
		.i_data_wr  (i_port_c_data_wr),
		.i_od_wr    (i_port_c_od_wr),
		.i_wdata    (i_wdata[gpio_pkg::C_W-1:0]),
		.i_alt_out  (c_alt_out),
		.i_alt_oe   (c_alt_oe),
		.i_pin_in   (i_port_c_pin),
		.o_pin_out  (o_port_c_pin),
		.o_pin_oe_n (o_port_c_pin_oe_n),
		.o_pin_level(c_level),
		.o_cfg      (o_port_c_cfg),
		.o_dir      (o_port_c_dir),
		.o_od       (o_port_c_od),
		.o_rd_data  (o_port_c_rd_data)
	);

	// strap follows the synchronised pad while reset is held, then freezes
	always_comb
	begin
		strap_next = i_srst ? b_level[gpio_pkg::B_STRAP] : strap_reg;
	end

	// strap register; no reset branch since reset itself loads it
	always_ff @(posedge i_clk)
	begin
		strap_reg <= strap_next;
	end

	// peripheral inputs: synchronised pad levels, ungated by configuration
	assign o_serial_one_receive = a_level[gpio_pkg::A_RX1];
	assign o_serial_two_receive = a_level[gpio_pkg::A_RX2];
	assign o_spi_one_master_in = a_level[gpio_pkg::A_SPI1_MI];
	assign o_spi_one_master_out = a_level[gpio_pkg::A_SPI1_MO];
	assign o_spi_one_clock = a_level[gpio_pkg::A_SPI1_CK];
	assign o_spi_two_master_in = a_level[gpio_pkg::A_SPI2_MI];
	assign o_spi_two_master_out = a_level[gpio_pkg::A_SPI2_MO];
	assign o_spi_two_clock = a_level[gpio_pkg::A_SPI2_CK];
	// a 48 mhz clock aliases at this sample rate; usable as a presence level only
	assign o_usb_ref_clock_in = a_level[gpio_pkg::A_USB_REF];
	assign o_can_receive_in = a_level[gpio_pkg::A_CAN_RX];
	assign o_timer_one_external_clock = a_level[gpio_pkg::A_TMR1_CLK];
	assign o_usb_minus_line = a_level[gpio_pkg::A_USB_MINUS];
	assign o_usb_plus_line = a_level[gpio_pkg::A_USB_PLUS];
	assign o_external_irq = b_level[gpio_pkg::B_CAP:gpio_pkg::B_IRQ0];
	assign o_spi_one_slave_select = b_level[gpio_pkg::B_SPI1_SEL];
	assign o_spi_two_slave_select = b_level[gpio_pkg::B_SPI2_SEL];
	assign o_timer_two_capture_b = b_level[gpio_pkg::B_CAP];
	assign o_ext_memory_ready = c_level[gpio_pkg::C_READY];
	assign o_boot_source_strap = strap_reg;

	// checks on the peripheral mapping and the strap
	strap_hold_a: assert property (@(posedge i_clk)
		!i_srst |=> $stable(o_boot_source_strap))
		else $error("strap changed outside reset");
	spi_slave_clock_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_port_a_cfg[gpio_pkg::A_SPI1_CK] && !i_spi_one_is_master)
		|=> o_port_a_pin_oe_n[gpio_pkg::A_SPI1_CK])
		else $error("slave spi clock driven");
	spi_master_clock_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_port_a_cfg[gpio_pkg::A_SPI1_CK] && i_spi_one_is_master && !o_port_a_od)
		|=> (!o_port_a_pin_oe_n[gpio_pkg::A_SPI1_CK]
		&& o_port_a_pin[gpio_pkg::A_SPI1_CK] == $past(i_spi_one_clock)))
		else $error("master spi clock not driven");
	stop_request_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_port_b_cfg[gpio_pkg::B_STOP] && !i_stop_request_n)
		|=> (!o_port_b_pin_oe_n[gpio_pkg::B_STOP] && !o_port_b_pin[gpio_pkg::B_STOP]))
		else $error("stop request not driven low");
	bank1_select_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_port_c_cfg[gpio_pkg::C_BANK1] && !i_ext_memory_bank1_select_n)
		|=> !o_port_c_pin_oe_n[gpio_pkg::C_BANK1])
		else $error("bank select not driven");
	// push-pull peripheral outputs reach their pads one cycle after the request
	serial_transmit_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_port_a_cfg[gpio_pkg::A_TX2] && !o_port_a_od)
		|=> (!o_port_a_pin_oe_n[gpio_pkg::A_TX2]
		&& o_port_a_pin[gpio_pkg::A_TX2] == $past(i_serial_two_transmit)))
		else $error("serial transmit not driven");
	can_transmit_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_port_a_cfg[gpio_pkg::A_CAN_TX] && !o_port_a_od)
		|=> (!o_port_a_pin_oe_n[gpio_pkg::A_CAN_TX]
		&& o_port_a_pin[gpio_pkg::A_CAN_TX] == $past(i_can_transmit_out)))
		else $error("can transmit not driven");
	synth_lock_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_port_b_cfg[gpio_pkg::B_LOCK] && !o_port_b_od)
		|=> (!o_port_b_pin_oe_n[gpio_pkg::B_LOCK]
		&& o_port_b_pin[gpio_pkg::B_LOCK] == $past(i_synth_lock)))
		else $error("lock status not driven");
	spi_slave_data_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_port_a_cfg[gpio_pkg::A_SPI2_MI] && !i_spi_two_is_master && !o_port_a_od)
		|=> (!o_port_a_pin_oe_n[gpio_pkg::A_SPI2_MI]
		&& o_port_a_pin[gpio_pkg::A_SPI2_MI] == $past(i_spi_two_master_in)))
		else $error("slave spi data not driven");
	usb_release_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_port_a_cfg[gpio_pkg::A_USB_MINUS] && !i_usb_drive)
		|=> o_port_a_pin_oe_n[gpio_pkg::A_USB_MINUS])
		else $error("usb line driven while released");
	// peripheral inputs are the pad level two cycles late, whatever the configuration
	serial_receive_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_serial_one_receive == $past(i_port_a_pin[gpio_pkg::A_RX1], 2))
		else $error("serial receive level wrong");
	port_a_inputs_a: assert property (@(posedge i_clk) disable iff (i_srst)
		{o_usb_ref_clock_in, o_can_receive_in, o_timer_one_external_clock}
		== {$past(i_port_a_pin[gpio_pkg::A_USB_REF], 2),
		$past(i_port_a_pin[gpio_pkg::A_CAN_RX], 2),
		$past(i_port_a_pin[gpio_pkg::A_TMR1_CLK], 2)})
		else $error("port a peripheral input wrong");
	irq_inputs_a: assert property (@(posedge i_clk) disable iff (i_srst)
		{o_external_irq, o_timer_two_capture_b}
		== {$past(i_port_b_pin[gpio_pkg::B_CAP:gpio_pkg::B_IRQ0], 2),
		$past(i_port_b_pin[gpio_pkg::B_CAP], 2)})
		else $error("irq or capture input wrong");
	slave_select_a: assert property (@(posedge i_clk) disable iff (i_srst)
		{o_spi_one_slave_select, o_spi_two_slave_select}
		== {$past(i_port_b_pin[gpio_pkg::B_SPI1_SEL], 2),
		$past(i_port_b_pin[gpio_pkg::B_SPI2_SEL], 2)})
		else $error("slave select level wrong");
	memory_ready_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_ext_memory_ready == $past(i_port_c_pin[gpio_pkg::C_READY], 2))
		else $error("memory ready level wrong");
	strap_high_c: cover property (@(posedge i_clk) i_srst ##1 !i_srst && o_boot_source_strap);
	spi_master_c: cover property (@(posedge i_clk) i_spi_one_is_master
		&& o_port_a_cfg[gpio_pkg::A_SPI1_CK]);
	usb_pair_c: cover property (@(posedge i_clk) i_usb_drive
		&& !o_port_a_pin_oe_n[gpio_pkg::A_USB_PLUS]);
endmodule // gpio_ports
`default_nettype wire

// ---- common/gpio_pkg.sv ----
`default_nettype none
package gpio_pkg;
	localparam int A_W = 16;
	localparam int B_W = 13;
	localparam int C_W = 5;
	localparam int WDATA_W = 16;
	localparam int IRQ_N = 5;
	// reset values, one bit repeated across each port
	localparam logic CFG_RST = 1'b0;
	localparam logic DIR_RST = 1'b0;
	localparam logic DATA_RST = 1'b0;
	localparam logic OD_RST = 1'b0;
	localparam logic OE_N_IDLE = 1'b1;
	// port a line positions
	localparam int A_RX1 = 0;
	localparam int A_TX1 = 1;
	localparam int A_RX2 = 2;
	localparam int A_TX2 = 3;
	localparam int A_SPI1_MI = 4;
	localparam int A_SPI1_MO = 5;
	localparam int A_SPI1_CK = 6;
	localparam int A_SPI2_MI = 7;
	localparam int A_SPI2_MO = 8;
	localparam int A_SPI2_CK = 9;
	localparam int A_USB_REF = 10;
	localparam int A_CAN_RX = 11;
	localparam int A_CAN_TX = 12;
	localparam int A_TMR1_CLK = 13;
	localparam int A_USB_MINUS = 14;
	localparam int A_USB_PLUS = 15;
	// port b and port c line positions
	localparam int B_STRAP = 6;
	localparam int B_STOP = 7;
	localparam int B_IRQ0 = 8;
	localparam int B_SPI1_SEL = 9;
	localparam int B_SPI2_SEL = 10;
	localparam int B_LOCK = 11;
	localparam int B_CAP = 12;
	localparam int C_READY = 0;
	localparam int C_BANK1 = 4;
endpackage
`default_nettype wire

// ---- design/gpio_port_lines.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_port_lines #(
	parameter int W = 16
) (
	input  wire logic         i_clk,
	input  wire logic         i_srst,
	input  wire logic         i_cfg_wr,
	input  wire logic         i_dir_wr,
	input  wire logic         i_data_wr,
	input  wire logic         i_od_wr,
	input  wire logic [W-1:0] i_wdata,
	input  wire logic [W-1:0] i_alt_out,
	input  wire logic [W-1:0] i_alt_oe,
	input  wire logic [W-1:0] i_pin_in,
	output logic      [W-1:0] o_pin_out,
	output logic      [W-1:0] o_pin_oe_n,
	output logic      [W-1:0] o_pin_level,
	output logic      [W-1:0] o_cfg,
	output logic      [W-1:0] o_dir,
	output logic              o_od,
	output logic      [W-1:0] o_rd_data
);
	logic [W-1:0] cfg_reg, cfg_next, dir_reg, dir_next;
	logic [W-1:0] latch_reg, latch_next, out_reg, out_next;
	logic [W-1:0] oe_n_reg, oe_n_next, rd_reg, rd_next;
	logic [W-1:0] meta_reg, level_reg, drive_en, drive_val;
	logic         od_reg, od_next;

	// pad synchroniser; no reset so the strap level survives reset
	always_ff @(posedge i_clk)
	begin
		meta_reg <= i_pin_in;
		level_reg <= meta_reg;
	end

	// next values of registers and pad drivers
	always_comb
	begin
		cfg_next = i_cfg_wr ? i_wdata : cfg_reg;
		dir_next = i_dir_wr ? i_wdata : dir_reg;
		latch_next = i_data_wr ? i_wdata : latch_reg;
		od_next = i_od_wr ? i_wdata[0] : od_reg;
		// cfg selects peripheral, else dir picks gpio in or out
		drive_en = (cfg_reg & i_alt_oe) | (~cfg_reg & dir_reg);
		drive_val = (cfg_reg & i_alt_out) | (~cfg_reg & latch_reg);
		out_next = drive_val;
		// open drain only enables the driver for a low level
		oe_n_next = ~(drive_en & ({W{~od_reg}} | ~drive_val));
		// driven lines read the driver input even when od releases a high
		rd_next = (drive_en & drive_val) | (~drive_en & level_reg);
	end

	// register stage
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			cfg_reg <= {W{gpio_pkg::CFG_RST}};
			dir_reg <= {W{gpio_pkg::DIR_RST}};
			latch_reg <= {W{gpio_pkg::DATA_RST}};
			od_reg <= gpio_pkg::OD_RST;
			out_reg <= {W{gpio_pkg::DATA_RST}};
			oe_n_reg <= {W{gpio_pkg::OE_N_IDLE}};
			rd_reg <= {W{gpio_pkg::DATA_RST}};
		end
		else
		begin
			cfg_reg <= cfg_next;
			dir_reg <= dir_next;
			latch_reg <= latch_next;
			od_reg <= od_next;
			out_reg <= out_next;
			oe_n_reg <= oe_n_next;
			rd_reg <= rd_next;
		end
	end

	assign o_pin_out = out_reg;
	assign o_pin_oe_n = oe_n_reg;
	assign o_pin_level = level_reg;
	assign o_cfg = cfg_reg;
	assign o_dir = dir_reg;
	assign o_od = od_reg;
	assign o_rd_data = rd_reg;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	// checks on register and pad behaviour
	reset_idle_a: assert property (@(posedge i_clk) disable iff (1'b0) i_srst |=>
		(o_pin_oe_n == {W{1'b1}} && o_cfg == '0 && o_dir == '0))
		else $error("pins driven after reset");
	cfg_write_a: assert property (i_cfg_wr |=> o_cfg == $past(i_wdata))
		else $error("config write lost");
	latch_write_a: assert property (i_data_wr |=> latch_reg == $past(i_wdata))
		else $error("latch not updated");
	gpio_low_a: assert property (1'b1 |=>
		((~$past(cfg_reg) & $past(dir_reg) & ~$past(latch_reg) & o_pin_oe_n) == '0))
		else $error("gpio low not driven");
	gpio_quiet_a: assert property (1'b1 |=>
		((~$past(cfg_reg) & ~$past(dir_reg) & ~o_pin_oe_n) == '0))
		else $error("input line driven");
	open_drain_a: assert property (od_reg |=>
		(($past(drive_en) & $past(drive_val) & ~o_pin_oe_n) == '0))
		else $error("open drain drove high");
	read_input_a: assert property (1'b1 |=>
		(((o_rd_data ^ $past(level_reg)) & ~$past(drive_en)) == '0))
		else $error("input read wrong");
	read_output_a: assert property (1'b1 |=>
		(((o_rd_data ^ $past(drive_val)) & $past(drive_en)) == '0))
		else $error("output read wrong");
	gpio_drive_c: cover property (i_dir_wr ##1 i_data_wr ##2 o_pin_oe_n != {W{1'b1}});
	open_drain_c: cover property (od_reg && (drive_en & drive_val) != '0);
endmodule // gpio_port_lines
`default_nettype wire

// ---- tb/board_pads.sv ----
`timescale 1ns/1ps
`default_nettype none
module board_pads #(
	parameter int W = 16
) (
	input  wire logic [W-1:0] i_pin_out,
	input  wire logic [W-1:0] i_pin_oe_n,
	input  wire logic [W-1:0] i_ext_val,
	input  wire logic [W-1:0] i_ext_en,
	output logic      [W-1:0] o_level
);
	// device drive wins, then a board driver, else the pull-up; a released line never keeps its value
	always_comb
	begin
		for (int i = 0; i < W; i++)
			o_level[i] = !i_pin_oe_n[i] ? i_pin_out[i] : (i_ext_en[i] ? i_ext_val[i] : 1'b1);
	end
endmodule // board_pads
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk;
	logic        srst;
	logic [15:0] wdata;
	logic [11:0] wr_v;
	logic [16:0] per;
	logic [15:0] ev [3];
	logic [15:0] ee [3];
	logic [15:0] dir [3];
	logic [15:0] dat [3];
	logic [15:0] drv [3];
	logic [15:0] val [3];
	logic [15:0] lvl [3];
	logic [15:0] act;
	logic [15:0] m;
	logic [2:0]  od;
	logic [31:0] seed;
	logic [31:0] r;
	logic [31:0] x;
	logic        alt;
	logic        strap;
	int          error_cnt;
	int          tests_run;
	wire  [15:0] p_out [3];
	wire  [15:0] p_oen [3];
	wire  [15:0] p_lvl [3];
	wire  [15:0] p_cfg [3];
	wire  [15:0] p_dir [3];
	wire  [15:0] p_rd [3];
	wire  [2:0]  p_od;
	wire  [22:0] rx;

	// upper lines of the narrow ports are tied off so the full-width pad models read no float
	assign p_out[1][15:13] = 3'h0;
	assign p_out[2][15:5] = 11'h000;
	assign p_oen[1][15:13] = 3'h7;
	assign p_oen[2][15:5] = 11'h7ff;
	assign p_cfg[1][15:13] = 3'h0;
	assign p_cfg[2][15:5] = 11'h000;
	assign p_dir[1][15:13] = 3'h0;
	assign p_dir[2][15:5] = 11'h000;
	assign p_rd[1][15:13] = 3'h0;
	assign p_rd[2][15:5] = 11'h000;

	gpio_ports dut_u (
		.i_clk(clk), .i_srst(srst), .i_wdata(wdata),
		.i_port_a_cfg_wr(wr_v[0]), .i_port_a_dir_wr(wr_v[1]), .i_port_a_data_wr(wr_v[2]),
		.i_port_a_od_wr(wr_v[3]), .i_port_b_cfg_wr(wr_v[4]), .i_port_b_dir_wr(wr_v[5]),
		.i_port_b_data_wr(wr_v[6]), .i_port_b_od_wr(wr_v[7]), .i_port_c_cfg_wr(wr_v[8]),
		.i_port_c_dir_wr(wr_v[9]), .i_port_c_data_wr(wr_v[10]), .i_port_c_od_wr(wr_v[11]),
		.o_port_a_cfg(p_cfg[0]), .o_port_a_dir(p_dir[0]), .o_port_a_od(p_od[0]),
		.o_port_a_rd_data(p_rd[0]), .o_port_b_cfg(p_cfg[1][12:0]), .o_port_b_dir(p_dir[1][12:0]),
		.o_port_b_od(p_od[1]), .o_port_b_rd_data(p_rd[1][12:0]), .o_port_c_cfg(p_cfg[2][4:0]),
		.o_port_c_dir(p_dir[2][4:0]), .o_port_c_od(p_od[2]), .o_port_c_rd_data(p_rd[2][4:0]),
		.i_port_a_pin(p_lvl[0]), .o_port_a_pin(p_out[0]), .o_port_a_pin_oe_n(p_oen[0]),
		.i_port_b_pin(p_lvl[1][12:0]), .o_port_b_pin(p_out[1][12:0]),
		.o_port_b_pin_oe_n(p_oen[1][12:0]), .i_port_c_pin(p_lvl[2][4:0]),
		.o_port_c_pin(p_out[2][4:0]), .o_port_c_pin_oe_n(p_oen[2][4:0]),
		.i_serial_one_transmit(per[0]), .i_serial_two_transmit(per[1]),
		.i_spi_one_is_master(per[2]), .i_spi_one_master_in(per[3]), .i_spi_one_master_out(per[4]),
		.i_spi_one_clock(per[5]), .i_spi_two_is_master(per[6]), .i_spi_two_master_in(per[7]),
		.i_spi_two_master_out(per[8]), .i_spi_two_clock(per[9]), .i_can_transmit_out(per[10]),
		.i_usb_drive(per[11]), .i_usb_minus_line(per[12]), .i_usb_plus_line(per[13]),
		.i_stop_request_n(per[14]), .i_synth_lock(per[15]),
		.i_ext_memory_bank1_select_n(per[16]), .o_serial_one_receive(rx[0]),
		.o_serial_two_receive(rx[1]), .o_spi_one_master_in(rx[2]), .o_spi_one_master_out(rx[3]),
		.o_spi_one_clock(rx[4]), .o_spi_two_master_in(rx[5]), .o_spi_two_master_out(rx[6]),
		.o_spi_two_clock(rx[7]), .o_usb_ref_clock_in(rx[8]), .o_can_receive_in(rx[9]),
		.o_timer_one_external_clock(rx[10]), .o_usb_minus_line(rx[11]), .o_usb_plus_line(rx[12]),
		.o_external_irq(rx[17:13]), .o_spi_one_slave_select(rx[18]),
		.o_spi_two_slave_select(rx[19]), .o_timer_two_capture_b(rx[20]),
		.o_ext_memory_ready(rx[21]), .o_boot_source_strap(rx[22])
	);

	// one board model per port, full width; unused upper lines are masked in every compare
	for (genvar g = 0; g < 3; g++)
	begin : g_pad
		board_pads #(.W(16)) pad_u (.i_pin_out(p_out[g]), .i_pin_oe_n(p_oen[g]),
			.i_ext_val(ev[g]), .i_ext_en(ee[g]), .o_level(p_lvl[g]));
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [15:0] msk(int p);
		return (p == 0) ? 16'hffff : ((p == 1) ? 16'h1fff : 16'h001f);
	endfunction

	// expected peripheral drive {enable, value} per port for peripheral inputs q
	function automatic logic [31:0] alt_x(int p, logic [16:0] q);
		if (p == 1)
			return {16'h0880, 4'h0, q[15], 3'h0, q[14], 7'h00};
		if (p == 2)
			return {16'h0010, 11'h000, q[16], 4'h0};
		return {q[11], q[11], 1'b0, 1'b1, 2'b00, q[6], q[6], ~q[6], q[2], q[2], ~q[2], 1'b1,
			1'b0, 1'b1, 1'b0, q[13], q[12], 1'b0, q[10], 2'b00, q[9:7], q[5:3], q[1], 1'b0,
			q[0], 1'b0};
	endfunction

	task automatic tick();
		@(posedge clk);
		#10;
	endtask

	// k = port * 4 + register (0 cfg, 1 dir, 2 data, 3 open drain)
	task automatic wr(input int k, input logic [15:0] d);
		wr_v = 12'h001 << k;
		wdata = d;
		tick();
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// hold reset with the board driving the strap level, then check the idle state
	task automatic reset_run();
		srst = 1'b1;
		for (int p = 0; p < 3; p++)
		begin
			ee[p] = (p == 1) ? 16'h0040 : 16'h0000;
			ev[p] = {16{strap}};
		end
		repeat (20) tick();
		for (int p = 0; p < 3; p++)
		begin
			check(p_oen[p] & msk(p), msk(p));
			check({p_cfg[p] & msk(p), p_dir[p] & msk(p)}, 32'h0000_0000);
		end
		check(rx[22], strap);
		srst = 1'b0;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// hang guard, far beyond the few hundred cycles the run needs
	initial
	begin
		repeat (3000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		seed = 32'h0000_1178;
		wr_v = 12'h000;
		wdata = 16'h0000;
		per = 17'h00000;
		error_cnt = 0;
		tests_run = 0;
		r = rnd();
		strap = r[0];
		reset_run();
		// pass 0 is the open-drain corner, 1..8 peripheral mode, the rest random gpio
		for (int i = 0; i < 21; i++)
		begin
			// a second reset mid-run must sample the opposite strap level
			if (i == 11)
			begin
				strap = ~strap;
				reset_run();
			end
			alt = (i >= 1 && i <= 8);
			for (int p = 0; p < 3; p++)
			begin
				r = rnd();
				dat[p] = (i == 0) ? 16'h5a5a : r[15:0];
				dir[p] = (i == 0) ? 16'hffff : r[31:16];
				od[p] = (i == 0) ? 1'b1 : r[31] ^ r[0];
				wr(p * 4 + 2, dat[p]);
				wr(p * 4 + 1, dir[p]);
				wr(p * 4, {16{alt}});
				wr(p * 4 + 3, {15'h0000, od[p]});
			end
			r = rnd();
			per = r[16:0];
			wr_v = 12'h000;
			// board drives random levels onto open-drain highs too, so read-back must still give the driver input
			for (int p = 0; p < 3; p++)
			begin
				x = alt ? alt_x(p, per) : {dir[p], dat[p]};
				drv[p] = x[31:16];
				val[p] = x[15:0];
				r = rnd();
				ev[p] = r[15:0];
				ee[p] = ~drv[p] | ({16{od[p]}} & drv[p] & val[p]);
				act = drv[p] & ~({16{od[p]}} & val[p]);
				lvl[p] = (act & val[p]) | (~act & ev[p]);
			end
			repeat (5) tick();
			for (int p = 0; p < 3; p++)
			begin
				m = msk(p);
				act = drv[p] & ~({16{od[p]}} & val[p]);
				check(p_cfg[p] & m, {16{alt}} & m);
				check({p_dir[p] & m, 15'h0000, p_od[p]}, {dir[p] & m, 15'h0000, od[p]});
				check(p_oen[p] & m, ~act & m);
				check(p_out[p] & drv[p] & m, val[p] & drv[p] & m);
				check(p_rd[p] & m, ((drv[p] & val[p]) | (~drv[p] & lvl[p])) & m);
			end
			check(rx[21:0], {lvl[2][0], lvl[1][12], lvl[1][10], lvl[1][9], lvl[1][12:8],
				lvl[0][15:13], lvl[0][11:4], lvl[0][2], lvl[0][0]});
			check(rx[22], strap);
		end
		give_verdict();
	end
endmodule // tb
`default_nettype wire
